// ==== inc/tss_pkg.sv ====
// shared constants and types for the three-state sequencer
// assumes a single clock domain and an active-low asynchronous reset
package tss_pkg;

    localparam int unsigned STATE_W = 2;

    typedef enum logic [STATE_W-1:0] {
        TSS_ST_A      = 2'h0,
        TSS_ST_B      = 2'h1,
        TSS_ST_C      = 2'h2,
        TSS_ST_UNUSED = 2'h3
    } tss_state_t;

    // synchroniser depth for every pin input
    localparam int unsigned SYNC_STAGES = 2;

    // bit positions of the pin bundle fed through the synchroniser
    localparam int unsigned PIN_START   = 0;
    localparam int unsigned PIN_HOLD    = 1;
    localparam int unsigned PIN_RESET   = 2;
    localparam int unsigned PIN_PRELOAD = 3;
    localparam int unsigned PIN_OUT_DIS = 4;
    localparam int unsigned PIN_W       = 5;

    // values after the asynchronous reset
    localparam tss_state_t STATE_RST = TSS_ST_A;
    localparam logic       HALT_RST  = 1'b0;
    localparam logic       OE_RST    = 1'b0;

endpackage : tss_pkg

// ==== rtl/tss_sync.sv ====
// two-flop synchroniser for a bundle of independent level inputs
// assumes each bit is a slow level; no bus coherency across bits
`timescale 1ns/10ps
module tss_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             arst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    // first stage is read by the second stage only
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule : tss_sync

// ==== rtl/tss_sequencer.sv ====
// three-state sequencer: state register, halt flag and state indicators
// assumes start, hold, reset, preload and output-disable arrive as pins
// Overview of operation
// [RULE1] after initialisation sit in A until start is sampled high
// [RULE2] cycle A to B to C to A, then wait in A for start
// [RULE3] reset high sends the sequencer to A at the next edge
// [RULE4] reset taken in B sets halt until next start into B
// [RULE5] state_b_flag high only in B, state_c_flag only in C
// [RULE6] hold keeps B or C until hold drops or reset rises
// [RULE7] A advances to B only on start high with reset low
// [RULE8] halt cleared on A to B, kept while staying in A
// [RULE9] state in two-bit vector, B is one and C is two
// [RULE10] in B reset beats hold; reset sets halt, else halt zero
// [RULE11] in C stay only on hold without reset; halt zero always
// [RULE12] preload input forces the state register into A
// [RULE13] A is zero; unused code three returns to A next clock
`timescale 1ns/10ps
module tss_sequencer (
    input  wire logic                          clock,
    input  wire logic                          arst_n,
    input  wire logic                          start,
    input  wire logic                          hold,
    input  wire logic                          seq_reset,
    input  wire logic                          preload,
    input  wire logic                          out_dis,
    output logic      [tss_pkg::STATE_W-1:0]   state_bits,
    output logic                               halt_q,
    output logic                               state_b_flag,
    output logic                               state_c_flag,
    output logic                               out_oe
);
    import tss_pkg::*;

    logic [PIN_W-1:0] pins_raw;
    logic [PIN_W-1:0] pins_s;
    logic             start_s;
    logic             hold_s;
    logic             reset_s;
    logic             preload_s;
    logic             out_dis_s;
    tss_state_t       state_q;
    tss_state_t       state_d;
    logic             halt_d;

    // start counts only when no reset is asked for in the same cycle
    function automatic logic start_taken(
        input logic start_lvl,
        input logic reset_lvl
    );
        return start_lvl && !reset_lvl;
    endfunction : start_taken

    assign pins_raw[PIN_START]   = start;
    assign pins_raw[PIN_HOLD]    = hold;
    assign pins_raw[PIN_RESET]   = seq_reset;
    assign pins_raw[PIN_PRELOAD] = preload;
    assign pins_raw[PIN_OUT_DIS] = out_dis;

    // pins come from another party; all go through two flops
    tss_sync #(
        .WIDTH    (PIN_W)
    ) u_sync (
        .clock    (clock),
        .arst_n   (arst_n),
        .async_in (pins_raw),
        .sync_out (pins_s)
    );

    assign start_s   = pins_s[PIN_START];
    assign hold_s    = pins_s[PIN_HOLD];
    assign reset_s   = pins_s[PIN_RESET];
    assign preload_s = pins_s[PIN_PRELOAD];
    assign out_dis_s = pins_s[PIN_OUT_DIS];

    // next state and halt value, one decision per state
    always_comb begin
        state_d = state_q;
        halt_d  = halt_q;
        case (state_q)
            TSS_ST_A: begin
                if (start_taken(start_s, reset_s)) begin // RULE7 RULE2
                    state_d = TSS_ST_B;
                    halt_d  = 1'b0; // RULE8
                end else begin
                    state_d = TSS_ST_A; // RULE1
                    halt_d  = halt_q; // RULE8 RULE4
                end
            end
            TSS_ST_B: begin
                if (reset_s) begin // RULE10 RULE3
                    state_d = TSS_ST_A;
                    halt_d  = 1'b1; // RULE4
                end else if (hold_s) begin // RULE6
                    state_d = TSS_ST_B;
                    halt_d  = 1'b0;
                end else begin
                    state_d = TSS_ST_C; // RULE2
                    halt_d  = 1'b0;
                end
            end
            TSS_ST_C: begin
                if (hold_s && !reset_s) begin // RULE11 RULE6
                    state_d = TSS_ST_C;
                end else begin
                    state_d = TSS_ST_A; // RULE2 RULE3
                end
                halt_d = 1'b0; // RULE11
            end
            default: begin
                // code three is never entered normally; recover to A
                state_d = TSS_ST_A; // RULE13
                halt_d  = halt_q;
            end
        endcase
    end

    // preload wins over the state decision so test can force A
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= STATE_RST;
        end else if (preload_s) begin
            state_q <= TSS_ST_A; // RULE12
        end else begin
            state_q <= state_d; // RULE9
        end
    end

    // halt is left untouched by preload; it only records a reset in B
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            halt_q <= HALT_RST;
        end else if (preload_s) begin
            halt_q <= halt_q;
        end else begin
            halt_q <= halt_d; // RULE4
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            out_oe <= OE_RST;
        end else begin
            out_oe <= !out_dis_s;
        end
    end

    assign state_bits   = state_q; // RULE9
    assign state_b_flag = (state_q == TSS_ST_B); // RULE5
    assign state_c_flag = (state_q == TSS_ST_C); // RULE5

    // checks on the synchronised view of the pins, save AST_PIN_LATENCY and AST_START_PIN_LATENCY on the raw pins
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    AST_A_WAITS_FOR_START: assert property ( // RULE1
        (state_q == TSS_ST_A) && !(start_s && !reset_s) |=> (state_q == TSS_ST_A)
    ) else $error("left state A without a start");

    AST_A_TO_B: assert property ( // RULE7
        (state_q == TSS_ST_A) && start_s && !reset_s && !preload_s |=> (state_q == TSS_ST_B)
    ) else $error("start in A did not reach B");

    AST_CYCLE_ORDER: assert property ( // RULE2
        (state_q == TSS_ST_B) && !hold_s && !reset_s && !preload_s
        ##1 (state_q == TSS_ST_C) && !hold_s && !preload_s |=> (state_q == TSS_ST_A)
    ) else $error("B to C to A sequence broken");

    AST_RESET_TO_A: assert property ( // RULE3
        reset_s |=> (state_q == TSS_ST_A)
    ) else $error("reset did not return to state A");

    AST_HALT_SET_IN_B: assert property ( // RULE4
        (state_q == TSS_ST_B) && reset_s && !preload_s |=> halt_q && (state_q == TSS_ST_A)
    ) else $error("reset in B did not raise halt");

    AST_HALT_STICKS_IN_A: assert property ( // RULE4
        halt_q && (state_q == TSS_ST_A) && !start_s |=> halt_q
    ) else $error("halt dropped before a new start");

    AST_FLAGS: assert property ( // RULE5
        (state_b_flag == (state_bits == 2'h1)) && (state_c_flag == (state_bits == 2'h2))
        && !(state_b_flag && state_c_flag)
    ) else $error("state indicator flags wrong");

    AST_HOLD_B: assert property ( // RULE6
        (state_q == TSS_ST_B) && hold_s && !reset_s && !preload_s |=> (state_q == TSS_ST_B) && !halt_q
    ) else $error("hold did not keep state B");

    AST_HOLD_C: assert property ( // RULE11
        (state_q == TSS_ST_C) && hold_s && !reset_s && !preload_s |=> (state_q == TSS_ST_C)
    ) else $error("hold did not keep state C");

    AST_HALT_CLEAR_ON_START: assert property ( // RULE8
        (state_q == TSS_ST_A) && start_s && !reset_s && !preload_s |=> !halt_q
    ) else $error("halt not cleared on entry to B");

    AST_HALT_ZERO_FROM_C: assert property ( // RULE11
        (state_q == TSS_ST_C) && !preload_s |=> !halt_q
    ) else $error("halt raised while leaving C");

    AST_PRELOAD_A: assert property ( // RULE12
        preload_s |=> (state_q == TSS_ST_A) && $stable(halt_q)
    ) else $error("preload did not force state A");

    AST_NO_UNUSED_CODE: assert property ( // RULE13
        (state_bits == 2'h3) |=> (state_bits == 2'h0)
    ) else $error("unused state code did not recover");

    AST_PIN_LATENCY: assert property ( // RULE3
        seq_reset [*3] |-> ##1 (state_q == TSS_ST_A)
    ) else $error("reset pin not effective after synchroniser");

    // transitions and halt bookkeeping beyond the basic cycle
    AST_FLAGS_LOW_IN_A: assert property ( // RULE5
        (state_q == TSS_ST_A) |-> !state_b_flag && !state_c_flag
    ) else $error("state indicator high in state A");

    AST_HOLD_IGNORED_IN_A: assert property ( // RULE6
        (state_q == TSS_ST_A) && hold_s && !start_s |=> (state_q == TSS_ST_A)
    ) else $error("hold moved the sequencer out of A");

    AST_B_TO_C: assert property ( // RULE2
        (state_q == TSS_ST_B) && !reset_s && !hold_s && !preload_s |=> (state_q == TSS_ST_C) && !halt_q
    ) else $error("B did not advance to C");

    AST_C_TO_A: assert property ( // RULE11
        (state_q == TSS_ST_C) && !hold_s && !preload_s |=> (state_q == TSS_ST_A) && !halt_q
    ) else $error("C without hold did not return to A");

    AST_RESET_IN_C: assert property ( // RULE3
        (state_q == TSS_ST_C) && reset_s && !preload_s |=> (state_q == TSS_ST_A) && !halt_q
    ) else $error("reset in C did not return to A with halt low");

    AST_RESET_BEATS_HOLD: assert property ( // RULE10
        (state_q == TSS_ST_B) && reset_s && hold_s && !preload_s |=> (state_q == TSS_ST_A) && halt_q
    ) else $error("hold in B outranked reset");

    AST_START_REFUSED_IN_RESET: assert property ( // RULE7
        (state_q == TSS_ST_A) && start_s && reset_s |=> (state_q == TSS_ST_A) && $stable(halt_q)
    ) else $error("start accepted while reset asked");

    AST_HALT_KEPT_IN_A: assert property ( // RULE8
        (state_q == TSS_ST_A) && !start_taken(start_s, reset_s) |=> $stable(halt_q)
    ) else $error("halt changed while waiting in A");

    AST_HALT_ONLY_IN_A: assert property ( // RULE4
        halt_q |-> (state_q == TSS_ST_A)
    ) else $error("halt high outside state A");

    AST_HALT_RISE: assert property ( // RULE4
        $rose(halt_q) |-> $past((state_q == TSS_ST_B) && reset_s && !preload_s)
    ) else $error("halt rose without a reset in B");

    AST_HALT_FALL: assert property ( // RULE8
        $fell(halt_q) |-> (state_q == TSS_ST_B)
    ) else $error("halt fell other than on entry to B");

    AST_B_ENTRY: assert property ( // RULE2
        $rose(state_b_flag) |->
        $past((state_q == TSS_ST_A) && start_taken(start_s, reset_s) && !preload_s)
    ) else $error("state B entered other than from a start in A");

    AST_C_ENTRY: assert property ( // RULE2
        $rose(state_c_flag) |->
        $past((state_q == TSS_ST_B) && !reset_s && !hold_s && !preload_s)
    ) else $error("state C entered other than from B");

    AST_PRELOAD_BEATS_RESET: assert property ( // RULE12
        preload_s && reset_s && (state_q == TSS_ST_B) |=> (state_q == TSS_ST_A) && !halt_q
    ) else $error("reset in B outranked preload");

    AST_STATE_LEGAL: assert property ( // RULE13
        state_bits != 2'h3
    ) else $error("unused state code reached");

    // pin to state latency: two synchroniser flops, then the state flop
    // raw pin level is lost on the release edge, hence the past-reset guard
    AST_START_PIN_LATENCY: assert property ( // RULE7
        $past(arst_n) && start && !seq_reset && !preload ##2 (state_q == TSS_ST_A)
        |=> (state_q == TSS_ST_B)
    ) else $error("start pin not effective after synchroniser");

    // output enable simply trails the synchronised disable pin
    AST_OE_OFF: assert property (
        out_dis_s |=> !out_oe
    ) else $error("outputs driven while disabled");

    AST_OE_ON: assert property (
        $fell(out_dis_s) |=> out_oe
    ) else $error("outputs not driven after disable dropped");

    AST_OE_KEPT: assert property (
        !out_dis_s && out_oe |=> out_oe
    ) else $error("output enable dropped without a disable");

    COV_FULL_CYCLE: cover property (
        (state_q == TSS_ST_A) ##1 (state_q == TSS_ST_B) ##1 (state_q == TSS_ST_C) ##1 (state_q == TSS_ST_A)
    );
    COV_HALT_RAISED: cover property ((state_q == TSS_ST_B) ##1 halt_q);
    COV_HOLD_IN_C: cover property ((state_q == TSS_ST_C) [*3]);
    COV_PRELOAD: cover property (preload_s && (state_q != TSS_ST_A));
    COV_RESET_BEATS_HOLD: cover property ((state_q == TSS_ST_B) && reset_s && hold_s);

endmodule : tss_sequencer

// ==== tb/tss_ctrl_model.sv ====
// far-side controller model: drives the start, hold, reset, preload and disable pins
// assumes the bench hands it one command word per clock, changed just after the rising edge
`timescale 1ns/10ps
module tss_ctrl_model (
    input  wire logic [tss_pkg::PIN_W-1:0] cmd,
    output logic                           start,
    output logic                           hold,
    output logic                           seq_reset,
    output logic                           preload,
    output logic                           out_dis
);
    import tss_pkg::*;

    // plain level pins, no glitches: the block synchronises each one itself
    assign start     = cmd[PIN_START];
    assign hold      = cmd[PIN_HOLD];
    assign seq_reset = cmd[PIN_RESET];
    assign preload   = cmd[PIN_PRELOAD];
    assign out_dis   = cmd[PIN_OUT_DIS];
endmodule : tss_ctrl_model

// ==== tb/tb_tss_sequencer.sv ====
// self-checking bench: random pin traffic against a cycle model of the sequencer
// assumes a two-flop pin synchroniser ahead of the state logic, as the hand-over describes
`timescale 1ns/10ps
module tb_tss_sequencer;
    import tss_pkg::*;

    logic                clock;
    logic                arst_n;
    logic [PIN_W-1:0]    cmd;
    logic                start;
    logic                hold;
    logic                seq_reset;
    logic                preload;
    logic                out_dis;
    logic [STATE_W-1:0]  state_bits;
    logic                halt_q;
    logic                state_b_flag;
    logic                state_c_flag;
    logic                out_oe;
    logic [5:0]          exp_q[$];
    logic [5:0]          e;
    logic [PIN_W-1:0]    s1;
    logic [PIN_W-1:0]    s2;
    logic [31:0]         r;
    tss_state_t          m_st;
    logic                m_h;
    logic                m_oe;
    logic                arst_nx;
    int                  seed = 2;
    int                  cyc = 0;
    int                  num_errors = 0;
    int                  checked = 0;

    tss_ctrl_model i_tss_ctrl_model (.cmd(cmd), .start(start), .hold(hold), .seq_reset(seq_reset),
                                     .preload(preload), .out_dis(out_dis));

    tss_sequencer i_tss_sequencer (.clock(clock), .arst_n(arst_n), .start(start), .hold(hold),
                                   .seq_reset(seq_reset), .preload(preload), .out_dis(out_dis),
                                   .state_bits(state_bits), .halt_q(halt_q), .state_b_flag(state_b_flag),
                                   .state_c_flag(state_c_flag), .out_oe(out_oe));

    initial begin
        clock  = 1'b0;
        arst_n = 1'b0;
        cmd    = '0;
        forever #25 clock = ~clock;
    end

    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input logic [5:0] got, input logic [5:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // cycle model; the old synchroniser contents decide this edge's state
    always @(posedge clock) begin
        if (!arst_n) begin
            m_st = STATE_RST;
            m_h  = HALT_RST;
            m_oe = OE_RST;
            s1   = '0;
            s2   = '0;
        end else begin
            m_oe = !s2[PIN_OUT_DIS];
            if (s2[PIN_PRELOAD]) begin
                m_st = TSS_ST_A;
            end else begin
                case (m_st)
                    TSS_ST_A: if (s2[PIN_START] && !s2[PIN_RESET]) begin
                        m_st = TSS_ST_B;
                        m_h  = 1'b0;
                    end
                    TSS_ST_B: begin
                        m_h  = s2[PIN_RESET];
                        m_st = s2[PIN_RESET] ? TSS_ST_A : (s2[PIN_HOLD] ? TSS_ST_B : TSS_ST_C);
                    end
                    TSS_ST_C: begin
                        m_h  = 1'b0;
                        m_st = (s2[PIN_HOLD] && !s2[PIN_RESET]) ? TSS_ST_C : TSS_ST_A;
                    end
                    default: m_st = TSS_ST_A;
                endcase
            end
            s2 = s1;
            s1 = cmd;
        end
        cyc++;
        // second reset in mid-run tests recovery from an arbitrary state
        arst_nx = !(cyc < 16 || (cyc >= 1500 && cyc < 1504));
        if (arst_n && arst_nx) begin
            exp_q.push_back({m_oe, m_st == TSS_ST_C, m_st == TSS_ST_B, m_h, m_st});
        end
        arst_n <= arst_nx;
        r = $random(seed);
        cmd <= {&r[12:10], &r[9:6], &r[5:3], &r[2:1], r[0]};
        if (cyc == 3000) begin
            print_verdict();
        end
    end

    // one note per edge; compare once the edge's updates have settled
    always @(negedge clock) begin
        if (exp_q.size() > 0) begin
            e = exp_q.pop_front();
            check({4'h0, state_bits}, {4'h0, e[1:0]});
            check({5'h0, halt_q}, {5'h0, e[2]});
            check({3'h0, out_oe, state_c_flag, state_b_flag}, {3'h0, e[5:3]});
        end
    end

    // hang guard well beyond the 3000-cycle run
    initial begin
        repeat (4000) @(posedge clock);
        num_errors++;
        print_verdict();
    end
endmodule : tb_tss_sequencer
